// ==== rtl/mrr_responder.sv ====
/*
  Register-access command handler: slave for functions 03/04/06/16 and a
  master that issues one fixed request and stores read answers locally.
  Assumes framing (silence detection) and the parameter store are outside,
  on the same clock; rx_end_in marks the end of each received frame.
*/
`timescale 1ns/1ps
`include "mrr_cfg.svh"

module mrr_responder #(
  parameter int RESP_TIMEOUT_CYC = `MRR_RESP_TIMEOUT_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] station_in,
  input wire logic swap_in,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_end_in,
  output logic tx_valid_out,
  input wire logic tx_ready_in,
  output mrr_pkg::mrr_tx_beat_type tx_beat_out,
  output logic reg_rd_out,
  output logic reg_wr_out,
  output mrr_pkg::mrr_reg_req_type reg_req_out,
  input wire logic [15:0] reg_rdata_in,
  input wire logic mst_start_in,
  input wire mrr_pkg::mrr_mst_cmd_type mst_cmd_in,
  output logic mst_ready_out,
  output logic mst_done_out,
  output logic mst_err_out
);

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ `MRR_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_step

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  mrr_pkg::mrr_state_type st_ff;
  logic [7:0] buf_mem [`MRR_BUF_DEPTH];
  logic [8:0] len_ff;
  logic ovf_ff;
  logic [15:0] rx_crc_ff;
  logic [15:0] tx_crc_ff;
  logic [2:0] idx_ff;
  logic [2:0] hdr_len_ff;
  logic [7:0] fc_ff;
  logic [7:0] third_ff;
  logic [15:0] qty_ff;
  logic [15:0] addr_ff;
  logic [7:0] ptr_ff;
  logic is_input_ff;
  logic [15:0] rdata_ff;
  logic mst_tx_ff;
  logic mst_wait_ff;
  logic [7:0] mst_station_ff;
  logic [7:0] mst_fc_ff;
  logic [15:0] mst_local_ff;
  logic [31:0] tmo_ff;
  logic done_ff;
  logic err_ff;

  // ----------------------------------------------------------------
  // Frame decode
  // ----------------------------------------------------------------
  wire [7:0] fr_fc = buf_mem[1];
  wire [15:0] fr_a = {buf_mem[2], buf_mem[3]};
  wire [15:0] fr_q = {buf_mem[4], buf_mem[5]};
  wire [7:0] expect_station = mst_wait_ff ? mst_station_ff : station_in;
  wire frame_ok = !ovf_ff && (len_ff >= `MRR_MIN_LEN) && (rx_crc_ff == 16'h0000)
                  && (buf_mem[0] == expect_station);
  wire is_read = (fr_fc == `MRR_FC_RD_HOLD) || (fr_fc == `MRR_FC_RD_INPUT);
  wire is_w1 = fr_fc == `MRR_FC_WR_ONE;
  wire is_wm = fr_fc == `MRR_FC_WR_MULTI;
  wire len_fixed = len_ff == `MRR_FIXED_LEN;
  wire [8:0] wm_len = {fr_q[7:0], 1'b0} + `MRR_WM_OVERHEAD;
  wire len_wm = (fr_q[15:8] == 8'h00) && (len_ff == wm_len) && (buf_mem[6] == {fr_q[6:0], 1'b0});
  wire rd_qty_ok = (fr_q != 16'h0000) && (fr_q <= `MRR_MAX_RD_QTY);
  wire wm_qty_ok = (fr_q != 16'h0000) && (fr_q <= `MRR_MAX_WR_QTY);

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  // Pairs of a 32-bit value trade places when swapping
  wire [15:0] eff_addr = addr_ff ^ {15'h0000, swap_in};
  wire in_ctrl = !is_input_ff && (eff_addr <= `MRR_CTRL_MAP_LAST);
  wire in_sup = !is_input_ff && (eff_addr >= `MRR_SUP_MAP_FIRST)
                && (eff_addr <= `MRR_SUP_MAP_LAST);
  assign reg_rd_out = st_ff == mrr_pkg::S_RD;
  assign reg_wr_out = (st_ff == mrr_pkg::S_WR) && (qty_ff != 16'h0000);
  assign reg_req_out.is_input = is_input_ff;
  assign reg_req_out.region = in_ctrl ? mrr_pkg::REGION_CTRL_MAP :
                              in_sup ? mrr_pkg::REGION_SUP_MAP : mrr_pkg::REGION_NATIVE;
  assign reg_req_out.addr = eff_addr;
  assign reg_req_out.data = {buf_mem[ptr_ff], buf_mem[ptr_ff + 8'h01]};

  // ----------------------------------------------------------------
  // Transmit side
  // ----------------------------------------------------------------
  wire in_hdr = st_ff == mrr_pkg::S_TXHDR;
  wire [7:0] hdr_byte = (idx_ff == 3'h1) ? fc_ff :
                        ((idx_ff == 3'h2) && (hdr_len_ff == `MRR_HDR_SHORT)) ? third_ff :
                        buf_mem[{5'h00, idx_ff}];
  assign tx_valid_out = in_hdr || (st_ff == mrr_pkg::S_TXHI) || (st_ff == mrr_pkg::S_TXLO)
                        || (st_ff == mrr_pkg::S_CRCL) || (st_ff == mrr_pkg::S_CRCH);
  assign tx_beat_out.data = in_hdr ? hdr_byte :
                            (st_ff == mrr_pkg::S_TXHI) ? rdata_ff[15:8] :
                            (st_ff == mrr_pkg::S_TXLO) ? rdata_ff[7:0] :
                            (st_ff == mrr_pkg::S_CRCL) ? tx_crc_ff[7:0] : tx_crc_ff[15:8];
  assign tx_beat_out.last = st_ff == mrr_pkg::S_CRCH;
  wire tx_hs = tx_valid_out && tx_ready_in;
  wire hdr_done = idx_ff == (hdr_len_ff - 3'h1);

  assign mst_ready_out = (st_ff == mrr_pkg::S_IDLE) && !mst_wait_ff && (len_ff == 9'h000);
  assign mst_done_out = done_ff;
  assign mst_err_out = err_ff;

  // Frame memory holds no control state, so it carries no reset
  always_ff @(posedge clk_in) begin
    if (st_ff == mrr_pkg::S_IDLE && rx_valid_in && !len_ff[8]) begin
      buf_mem[len_ff[7:0]] <= rx_data_in;
    end else if (mst_start_in && mst_ready_out) begin
      buf_mem[0] <= mst_cmd_in.station;
      buf_mem[1] <= mst_cmd_in.fc;
      buf_mem[2] <= mst_cmd_in.addr[15:8];
      buf_mem[3] <= mst_cmd_in.addr[7:0];
      buf_mem[4] <= mst_cmd_in.value[15:8];
      buf_mem[5] <= mst_cmd_in.value[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Control
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_ff <= mrr_pkg::S_IDLE;
      len_ff <= 9'h000;
      ovf_ff <= 1'b0;
      rx_crc_ff <= `MRR_CRC_INIT;
      tx_crc_ff <= `MRR_CRC_INIT;
      idx_ff <= 3'h0;
      hdr_len_ff <= `MRR_HDR_ECHO;
      fc_ff <= 8'h00;
      third_ff <= 8'h00;
      qty_ff <= 16'h0000;
      addr_ff <= 16'h0000;
      ptr_ff <= 8'h00;
      is_input_ff <= 1'b0;
      rdata_ff <= 16'h0000;
      mst_tx_ff <= 1'b0;
      mst_wait_ff <= 1'b0;
      mst_station_ff <= 8'h00;
      mst_fc_ff <= 8'h00;
      mst_local_ff <= 16'h0000;
      tmo_ff <= 32'h0000_0000;
      done_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      err_ff <= 1'b0;
      case (st_ff)
        mrr_pkg::S_IDLE: begin
          if (rx_valid_in) begin
            len_ff <= len_ff[8] ? len_ff : len_ff + 9'h001;
            ovf_ff <= ovf_ff | len_ff[8];
            rx_crc_ff <= crc_step(rx_crc_ff, rx_data_in);
          end
          if (rx_end_in) begin
            st_ff <= mrr_pkg::S_CHECK;
          end else if (mst_start_in && mst_ready_out) begin
            mst_station_ff <= mst_cmd_in.station;
            mst_fc_ff <= mst_cmd_in.fc;
            mst_local_ff <= mst_cmd_in.local_addr;
            fc_ff <= mst_cmd_in.fc;
            hdr_len_ff <= `MRR_HDR_ECHO;
            idx_ff <= 3'h0;
            qty_ff <= 16'h0000;
            tx_crc_ff <= `MRR_CRC_INIT;
            mst_tx_ff <= 1'b1;
            st_ff <= mrr_pkg::S_TXHDR;
          end else if (mst_wait_ff) begin
            // A silent station must not hang the master for good
            tmo_ff <= tmo_ff + 32'h0000_0001;
            if (tmo_ff >= RESP_TIMEOUT_CYC[31:0]) begin
              mst_wait_ff <= 1'b0;
              err_ff <= 1'b1;
            end
          end
        end
        mrr_pkg::S_CHECK: begin
          len_ff <= 9'h000;
          ovf_ff <= 1'b0;
          rx_crc_ff <= `MRR_CRC_INIT;
          tx_crc_ff <= `MRR_CRC_INIT;
          idx_ff <= 3'h0;
          st_ff <= mrr_pkg::S_IDLE;
          if (frame_ok && mst_wait_ff) begin
            mst_wait_ff <= 1'b0;
            tmo_ff <= 32'h0000_0000;
            is_input_ff <= 1'b0;
            if (fr_fc == (mst_fc_ff | `MRR_FC_EXC_FLAG) || fr_fc != mst_fc_ff) begin
              err_ff <= 1'b1;
            end else if (is_read) begin
              // Read answers land in the local holding store
              qty_ff <= {9'h000, buf_mem[2][7:1]};
              ptr_ff <= `MRR_RESP_DATA_PTR;
              addr_ff <= mst_local_ff;
              mst_tx_ff <= 1'b1;
              st_ff <= mrr_pkg::S_WR;
            end else begin
              done_ff <= 1'b1;
            end
          end else if (frame_ok) begin
            mst_tx_ff <= 1'b0;
            if (is_read && len_fixed) begin
              hdr_len_ff <= `MRR_HDR_SHORT;
              st_ff <= mrr_pkg::S_TXHDR;
              addr_ff <= fr_a;
              is_input_ff <= fr_fc == `MRR_FC_RD_INPUT;
              fc_ff <= rd_qty_ok ? fr_fc : (fr_fc | `MRR_FC_EXC_FLAG);
              third_ff <= rd_qty_ok ? {fr_q[6:0], 1'b0} : `MRR_EXC_ILL_VALUE;
              qty_ff <= rd_qty_ok ? fr_q : 16'h0000;
            end else if (is_w1 && len_fixed) begin
              is_input_ff <= 1'b0;
              addr_ff <= fr_a;
              qty_ff <= 16'h0001;
              ptr_ff <= `MRR_WR_ONE_PTR;
              st_ff <= mrr_pkg::S_WR;
            end else if (is_wm && len_wm && wm_qty_ok) begin
              is_input_ff <= 1'b0;
              addr_ff <= fr_a;
              qty_ff <= fr_q;
              ptr_ff <= `MRR_WR_MULTI_PTR;
              st_ff <= mrr_pkg::S_WR;
            end else if (is_wm && len_wm) begin
              hdr_len_ff <= `MRR_HDR_SHORT;
              fc_ff <= fr_fc | `MRR_FC_EXC_FLAG;
              third_ff <= `MRR_EXC_ILL_VALUE;
              qty_ff <= 16'h0000;
              st_ff <= mrr_pkg::S_TXHDR;
            end else if (!is_read && !is_w1 && !is_wm) begin
              hdr_len_ff <= `MRR_HDR_SHORT;
              fc_ff <= fr_fc | `MRR_FC_EXC_FLAG;
              third_ff <= `MRR_EXC_ILL_FUNC;
              qty_ff <= 16'h0000;
              st_ff <= mrr_pkg::S_TXHDR;
            end
          end
        end
        mrr_pkg::S_WR: begin
          if (qty_ff == 16'h0000) begin
            if (mst_tx_ff) begin
              mst_tx_ff <= 1'b0;
              done_ff <= 1'b1;
              st_ff <= mrr_pkg::S_IDLE;
            end else begin
              fc_ff <= buf_mem[1];
              hdr_len_ff <= `MRR_HDR_ECHO;
              st_ff <= mrr_pkg::S_TXHDR;
            end
          end else begin
            qty_ff <= qty_ff - 16'h0001;
            addr_ff <= addr_ff + 16'h0001;
            ptr_ff <= ptr_ff + 8'h02;
          end
        end
        mrr_pkg::S_TXHDR: begin
          if (tx_hs) begin
            tx_crc_ff <= crc_step(tx_crc_ff, tx_beat_out.data);
            idx_ff <= idx_ff + 3'h1;
            if (hdr_done) begin
              st_ff <= (qty_ff != 16'h0000) ? mrr_pkg::S_RD : mrr_pkg::S_CRCL;
            end
          end
        end
        mrr_pkg::S_RD: begin
          st_ff <= mrr_pkg::S_RDCAP;
        end
        mrr_pkg::S_RDCAP: begin
          rdata_ff <= reg_rdata_in;
          st_ff <= mrr_pkg::S_TXHI;
        end
        mrr_pkg::S_TXHI: begin
          if (tx_hs) begin
            tx_crc_ff <= crc_step(tx_crc_ff, tx_beat_out.data);
            st_ff <= mrr_pkg::S_TXLO;
          end
        end
        mrr_pkg::S_TXLO: begin
          if (tx_hs) begin
            tx_crc_ff <= crc_step(tx_crc_ff, tx_beat_out.data);
            qty_ff <= qty_ff - 16'h0001;
            addr_ff <= addr_ff + 16'h0001;
            st_ff <= (qty_ff == 16'h0001) ? mrr_pkg::S_CRCL : mrr_pkg::S_RD;
          end
        end
        mrr_pkg::S_CRCL: begin
          if (tx_hs) begin
            st_ff <= mrr_pkg::S_CRCH;
          end
        end
        mrr_pkg::S_CRCH: begin
          if (tx_hs) begin
            st_ff <= mrr_pkg::S_IDLE;
            mst_wait_ff <= mst_tx_ff;
            mst_tx_ff <= 1'b0;
            tmo_ff <= 32'h0000_0000;
          end
        end
        default: begin
          st_ff <= mrr_pkg::S_IDLE;
        end
      endcase
    end
  end

endmodule : mrr_responder

// ==== rtl/mrr_cfg.svh ====
/*
  Constants for the register-access command handler: function codes,
  exception codes, limits, reserved holding ranges, CRC and timing counts.
  Assumes it is included by its bare name from rtl/.
*/
`ifndef MRR_CFG_SVH
`define MRR_CFG_SVH

// ----------------------------------------------------------------
// Function and exception codes
// ----------------------------------------------------------------
`define MRR_FC_RD_HOLD 8'h03
`define MRR_FC_RD_INPUT 8'h04
`define MRR_FC_WR_ONE 8'h06
`define MRR_FC_WR_MULTI 8'h10
`define MRR_FC_EXC_FLAG 8'h80
`define MRR_EXC_ILL_FUNC 8'h01
`define MRR_EXC_ILL_VALUE 8'h03

// ----------------------------------------------------------------
// Limits and frame layout
// ----------------------------------------------------------------
`define MRR_MAX_RD_QTY 16'h007d
`define MRR_MAX_WR_QTY 16'h007b
`define MRR_FIXED_LEN 9'h008
`define MRR_MIN_LEN 9'h004
`define MRR_WM_OVERHEAD 9'h009
`define MRR_BUF_DEPTH 256
`define MRR_WR_ONE_PTR 8'h04
`define MRR_WR_MULTI_PTR 8'h07
`define MRR_RESP_DATA_PTR 8'h03
`define MRR_HDR_SHORT 3'h3
`define MRR_HDR_ECHO 3'h6

// ----------------------------------------------------------------
// Reserved holding ranges, zero-based offsets from 400.001
// ----------------------------------------------------------------
`define MRR_CTRL_MAP_FIRST 16'h0000
`define MRR_CTRL_MAP_LAST 16'h0277
`define MRR_SUP_MAP_FIRST 16'h0a28
`define MRR_SUP_MAP_LAST 16'h0c98

// ----------------------------------------------------------------
// CRC and timing
// ----------------------------------------------------------------
`define MRR_CRC_INIT 16'hffff
`define MRR_CRC_POLY 16'ha001
`define MRR_CLK_MHZ 100
`define MRR_RESP_TIMEOUT_MS 1000
`define MRR_RESP_TIMEOUT_CYC (`MRR_RESP_TIMEOUT_MS * 1000 * `MRR_CLK_MHZ)

`endif

// ==== rtl/mrr_pkg.sv ====
/*
  Types for the register-access command handler: FSM states and the
  packed carriers of the register port, master command and transmit beat.
  Assumes mrr_cfg.svh supplies the numeric constants.
*/
package mrr_pkg;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_CHECK = 4'h1,
    S_WR = 4'h2,
    S_RD = 4'h3,
    S_RDCAP = 4'h4,
    S_TXHDR = 4'h5,
    S_TXHI = 4'h6,
    S_TXLO = 4'h7,
    S_CRCL = 4'h8,
    S_CRCH = 4'h9
  } mrr_state_type;

  typedef enum logic [1:0] {
    REGION_NATIVE = 2'h0,
    REGION_CTRL_MAP = 2'h1,
    REGION_SUP_MAP = 2'h2
  } mrr_region_type;

  typedef struct packed {
    logic is_input;
    mrr_region_type region;
    logic [15:0] addr;
    logic [15:0] data;
  } mrr_reg_req_type;

  typedef struct packed {
    logic [7:0] station;
    logic [7:0] fc;
    logic [15:0] addr;
    logic [15:0] value;
    logic [15:0] local_addr;
  } mrr_mst_cmd_type;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } mrr_tx_beat_type;

endpackage : mrr_pkg

// ==== verification/mrr_responder_checker.sv ====
/*
  Port checker for the register-access handler: link, store and master timing.
  Assumes it is bound onto mrr_responder and sees its ports only.
*/
`timescale 1ns/1ps
module mrr_responder_checker (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic rx_end_in,
  input wire logic tx_valid_out,
  input wire logic tx_ready_in,
  input wire mrr_pkg::mrr_tx_beat_type tx_beat_out,
  input wire logic reg_rd_out,
  input wire logic reg_wr_out,
  input wire mrr_pkg::mrr_reg_req_type reg_req_out,
  input wire logic mst_start_in,
  input wire logic mst_ready_out,
  input wire logic mst_done_out,
  input wire logic mst_err_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Bit0 swap may move the range edges, so the upper bounds keep one word clear
  wire logic hold_acc = (reg_rd_out || reg_wr_out) && !reg_req_out.is_input;
  sequence s_last_taken;
    tx_valid_out && tx_ready_in && tx_beat_out.last;
  endsequence
  sequence s_start_taken;
    mst_start_in && mst_ready_out;
  endsequence
  a_wr_holding: assert property (reg_wr_out |-> !reg_req_out.is_input)
    else $error("write aimed at input space");
  a_tx_hold: assert property (tx_valid_out && !tx_ready_in |=>
    tx_valid_out && $stable(tx_beat_out)) else $error("tx byte not held");
  a_ctrl_region: assert property (hold_acc && reg_req_out.addr <= 16'h0276 |->
    reg_req_out.region == mrr_pkg::REGION_CTRL_MAP) else $error("control range miss");
  a_sup_region: assert property (hold_acc && reg_req_out.addr inside {[16'h0a28:16'h0c97]}
    |-> reg_req_out.region == mrr_pkg::REGION_SUP_MAP) else $error("supervision range miss");
  a_frame_ends: assert property (s_last_taken |=> !tx_valid_out)
    else $error("bytes after frame end");
  a_master_sends: assert property (s_start_taken |=> tx_valid_out && !mst_ready_out)
    else $error("master request not sent");
  a_done_excl: assert property (mst_done_out |-> !mst_err_out)
    else $error("done and error together");
  a_rd_alone: assert property (reg_rd_out |-> !reg_wr_out ##1 !reg_rd_out)
    else $error("read strobe not single");
  a_end_check: assert property (rx_end_in |=>
    !tx_valid_out && !reg_wr_out && !reg_rd_out) else $error("output during check");
endmodule : mrr_responder_checker

bind mrr_responder mrr_responder_checker chk (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .rx_end_in(rx_end_in),
  .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in), .tx_beat_out(tx_beat_out),
  .reg_rd_out(reg_rd_out), .reg_wr_out(reg_wr_out), .reg_req_out(reg_req_out),
  .mst_start_in(mst_start_in), .mst_ready_out(mst_ready_out),
  .mst_done_out(mst_done_out), .mst_err_out(mst_err_out)
);

// ==== verification/mrr_station_model.sv ====
/*
  Far-side station and parameter store: sinks sent bytes, may stall,
  answers reads one cycle after the strobe.
  Assumes the bench empties got between exchanges.
*/
`timescale 1ns/1ps
module mrr_station_model (
  input wire logic clk_in,
  input wire logic stall_in,
  input wire logic tx_valid_in,
  input wire mrr_pkg::mrr_tx_beat_type tx_beat_in,
  output logic tx_ready_out,
  input wire logic reg_rd_in,
  input wire logic reg_wr_in,
  input wire mrr_pkg::mrr_reg_req_type reg_req_in,
  output logic [15:0] reg_rdata_out
);
  logic [7:0] got[$];
  logic [15:0] wr_addr = 16'h0000;
  logic [15:0] wr_data = 16'h0000;
  logic is_in = 1'b0;
  logic wr_ctrl = 1'b0;
  int n_wr = 0;
  int last_at = 0;
  initial tx_ready_out = 1'b1;
  initial reg_rdata_out = 16'h0000;
  always @(negedge clk_in) tx_ready_out <= stall_in ? ~tx_ready_out : 1'b1;
  always @(posedge clk_in) begin
    if (tx_valid_in && tx_ready_out) begin
      got.push_back(tx_beat_in.data);
      // Position of the last flag, zero when a later byte follows it
      last_at <= tx_beat_in.last ? got.size() : 0;
    end
    // Stale data is inverted so a sample one cycle late does not match
    reg_rdata_out <= reg_rd_in ? (reg_req_in.addr ^ 16'h5a00) : ~reg_rdata_out;
    if (reg_rd_in) is_in <= reg_req_in.is_input;
    if (reg_wr_in) begin
      n_wr <= n_wr + 1;
      wr_addr <= reg_req_in.addr;
      wr_data <= reg_req_in.data;
      wr_ctrl <= reg_req_in.region == mrr_pkg::REGION_CTRL_MAP;
    end
  end
endmodule : mrr_station_model

// ==== verification/mrr_responder_bench.sv ====
/*
  Bench for mrr_responder: frames in, answers and store accesses checked.
  Assumes mrr_station_model as far side, timeout shortened to 200.
*/
`timescale 1ns/1ps
module mrr_responder_bench;
  localparam logic [7:0] ST = 8'h11;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] station_in = ST;
  logic swap_in = 1'b0, rx_valid_in = 1'b0, rx_end_in = 1'b0, stall = 1'b0;
  logic mst_start_in = 1'b0;
  logic [7:0] rx_data_in = 8'h00;
  logic tx_valid_out, tx_ready_in, reg_rd_out, reg_wr_out;
  logic mst_ready_out, mst_done_out, mst_err_out;
  logic [15:0] reg_rdata_in;
  mrr_pkg::mrr_tx_beat_type tx_beat_out;
  mrr_pkg::mrr_reg_req_type reg_req_out;
  mrr_pkg::mrr_mst_cmd_type mst_cmd_in = '0;
  logic [7:0] q[$], e[$];
  int fails = 0, n_checks = 0, cyc = 0;
  always #5 clk_in = ~clk_in;
  mrr_responder #(.RESP_TIMEOUT_CYC(200)) dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .station_in(station_in), .swap_in(swap_in),
    .rx_valid_in(rx_valid_in), .rx_data_in(rx_data_in), .rx_end_in(rx_end_in),
    .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in), .tx_beat_out(tx_beat_out),
    .reg_rd_out(reg_rd_out), .reg_wr_out(reg_wr_out), .reg_req_out(reg_req_out),
    .reg_rdata_in(reg_rdata_in), .mst_start_in(mst_start_in), .mst_cmd_in(mst_cmd_in),
    .mst_ready_out(mst_ready_out), .mst_done_out(mst_done_out), .mst_err_out(mst_err_out));
  mrr_station_model mdl (
    .clk_in(clk_in), .stall_in(stall), .tx_valid_in(tx_valid_out),
    .tx_beat_in(tx_beat_out), .tx_ready_out(tx_ready_in), .reg_rd_in(reg_rd_out),
    .reg_wr_in(reg_wr_out), .reg_req_in(reg_req_out), .reg_rdata_out(reg_rdata_in));

  function automatic void seal(ref logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    b.push_back(c[7:0]);
    b.push_back(c[15:8]);
  endfunction : seal

  task automatic check(input string nm, input logic [15:0] ex, input logic [15:0] got);
    n_checks++;
    if (got !== ex) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask : check

  task automatic send(input logic bad);
    seal(q);
    if (bad) q[q.size() - 1] = ~q[q.size() - 1];
    mdl.got.delete();
    foreach (q[i]) begin
      @(negedge clk_in);
      rx_valid_in = 1'b1;
      rx_data_in = q[i];
    end
    @(negedge clk_in);
    rx_valid_in = 1'b0;
    rx_end_in = 1'b1;
    @(negedge clk_in);
    rx_end_in = 1'b0;
  endtask : send

  task automatic answer(input string nm);
    int i;
    seal(e);
    i = 0;
    while (mdl.got.size() < e.size() && i < 400) begin
      @(negedge clk_in);
      i++;
    end
    repeat (20) @(negedge clk_in);
    check({nm, " length"}, 16'(e.size()), 16'(mdl.got.size()));
    check({nm, " last"}, 16'(e.size()), 16'(mdl.last_at));
    foreach (e[k]) if (k < mdl.got.size()) check(nm, 16'(e[k]), 16'(mdl.got[k]));
  endtask : answer

  task automatic t_drop;
    q = {8'h12, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01};
    send(1'b0);
    repeat (40) @(negedge clk_in);
    check("foreign station", 16'h0000, 16'(mdl.got.size()));
    q = {ST, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01};
    send(1'b1);
    repeat (40) @(negedge clk_in);
    check("bad crc", 16'h0000, 16'(mdl.got.size()));
  endtask : t_drop

  task automatic t_read_hold;
    q = {ST, 8'h03, 8'h0a, 8'h28, 8'h00, 8'h02};
    send(1'b0);
    e = {ST, 8'h03, 8'h04, 8'h50, 8'h28, 8'h50, 8'h29};
    answer("read holding");
  endtask : t_read_hold

  task automatic t_read_input;
    swap_in = 1'b1;
    stall = 1'b1;
    q = {ST, 8'h04, 8'h00, 8'h10, 8'h00, 8'h02};
    send(1'b0);
    e = {ST, 8'h04, 8'h04, 8'h5a, 8'h11, 8'h5a, 8'h10};
    answer("read input swapped");
    check("input space", 16'h0001, 16'(mdl.is_in));
    swap_in = 1'b0;
    stall = 1'b0;
  endtask : t_read_input

  task automatic t_write_one;
    q = {ST, 8'h06, 8'h00, 8'h05, 8'hbe, 8'hef};
    send(1'b0);
    e = q[0:5];
    answer("write one echo");
    check("write addr", 16'h0005, mdl.wr_addr);
    check("write data", 16'hbeef, mdl.wr_data);
    check("control map", 16'h0001, 16'(mdl.wr_ctrl));
  endtask : t_write_one

  task automatic t_write_multi;
    int n0;
    n0 = mdl.n_wr;
    q = {ST, 8'h10, 8'h00, 8'h20, 8'h00, 8'h02, 8'h04, 8'h11, 8'h11, 8'h22, 8'h22};
    send(1'b0);
    e = q[0:5];
    answer("write multi echo");
    check("write count", 16'h0002, 16'(mdl.n_wr - n0));
    check("last addr", 16'h0021, mdl.wr_addr);
    check("last data", 16'h2222, mdl.wr_data);
  endtask : t_write_multi

  task automatic t_exception;
    q = {ST, 8'h05, 8'h00, 8'h00, 8'h00, 8'h01};
    send(1'b0);
    e = {ST, 8'h85, 8'h01};
    answer("unknown function");
    q = {ST, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
    send(1'b0);
    e = {ST, 8'h83, 8'h03};
    answer("zero quantity");
  endtask : t_exception

  task automatic t_master_read;
    int i;
    int n0;
    n0 = mdl.n_wr;
    mst_cmd_in = '{8'h22, 8'h03, 16'h0100, 16'h0002, 16'h0300};
    mdl.got.delete();
    @(negedge clk_in);
    mst_start_in = 1'b1;
    @(negedge clk_in);
    mst_start_in = 1'b0;
    e = {8'h22, 8'h03, 8'h01, 8'h00, 8'h00, 8'h02};
    answer("master read request");
    // Answer from the addressed station lands in the local store
    q = {8'h22, 8'h03, 8'h04, 8'hab, 8'hcd, 8'h12, 8'h34};
    send(1'b0);
    i = 0;
    while (mst_done_out !== 1'b1 && i < 40) begin
      @(negedge clk_in);
      i++;
    end
    check("master done", 16'h0001, 16'(mst_done_out));
    check("master store count", 16'h0002, 16'(mdl.n_wr - n0));
    check("master store addr", 16'h0301, mdl.wr_addr);
    check("master store data", 16'h1234, mdl.wr_data);
  endtask : t_master_read

  task automatic t_master;
    int i;
    mst_cmd_in = '{8'h22, 8'h03, 16'h0100, 16'h0001, 16'h0000};
    mdl.got.delete();
    @(negedge clk_in);
    mst_start_in = 1'b1;
    @(negedge clk_in);
    mst_start_in = 1'b0;
    e = {8'h22, 8'h03, 8'h01, 8'h00, 8'h00, 8'h01};
    answer("master request");
    i = 0;
    while (mst_err_out !== 1'b1 && i < 400) begin
      @(negedge clk_in);
      i++;
    end
    check("master timeout", 16'h0001, 16'(mst_err_out));
  endtask : t_master

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  // Ceiling well above the roughly 600 cycles the scenarios need
  always @(posedge clk_in) begin
    cyc++;
    if (cyc > 20000) begin
      fails++;
      summarize;
    end
  end

  initial begin
    repeat (6) @(negedge clk_in);
    rst_n_in = 1'b1;
    t_drop;
    t_read_hold;
    t_read_input;
    t_write_one;
    t_write_multi;
    t_exception;
    t_master_read;
    t_master;
    summarize;
  end
endmodule : mrr_responder_bench
